// ===== include/psbps_pkg.sv
// Constants and types for the pSRAM burst and power sequencing controller
package psbps_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;  // Word address width
  localparam int DATA_W = 16;  // Data bus width
  localparam int LEN_W = 8;  // Burst word count width
  localparam int CNT_W = 16;  // Timing counter width

  // ----------------------------------------------------------------
  // Clock and time conversion
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;  // System clock period
  localparam int NS_PER_US = 1000;  // Unit conversion

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int min_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cyc

  // Longest time in ns to whole cycles, rounded down, never below one
  function automatic int max_cyc(input int t_ns);
    int c;
    c = t_ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : max_cyc

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  localparam int T_BURST_MAX_NS = 8000;  // Longest read or write burst
  localparam int T_TRB_BL_NS = 26;  // Terminate recovery, fixed length burst
  localparam int T_TRB_CONT_NS = 70;  // Terminate recovery, continuous burst
  localparam int T_WR_REC_NS = 26;  // Recovery after last write datum
  localparam int T_PD_SETUP_NS = 20;  // Power enable low setup
  localparam int T_PD_HOLD_NS = 70;  // Power enable low hold
  localparam int T_WE_STBY_NS = 10;  // Write strobe quiet after select rises
  localparam int T_EXIT_SLEEP_US = 300;  // Select high after exit, sleep mode
  localparam int T_EXIT_PART_US = 1;  // Select high after exit, partial mode
  localparam int T_PWRUP_HIGH_US = 50;  // Power enable high after power-up

  // Derived cycle counts
  localparam int BURST_MAX_CYC = max_cyc(T_BURST_MAX_NS);
  localparam int TRB_BL_CYC = min_cyc(T_TRB_BL_NS);
  localparam int TRB_CONT_CYC = min_cyc(T_TRB_CONT_NS);
  localparam int WR_REC_CYC = min_cyc(T_WR_REC_NS);
  localparam int PD_SETUP_CYC = min_cyc(T_PD_SETUP_NS);
  localparam int PD_HOLD_CYC = min_cyc(T_PD_HOLD_NS);
  localparam int WE_STBY_CYC = min_cyc(T_WE_STBY_NS);
  localparam int EXIT_PART_CYC = min_cyc(T_EXIT_PART_US * NS_PER_US);
  localparam int PWRUP_HIGH_CYC = min_cyc(T_PWRUP_HIGH_US * NS_PER_US);

  // Burst clocks edges of latency before first write datum
  localparam int WR_LATENCY = 3;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_LATCH,
    ST_RDATA,
    ST_WLAT,
    ST_WDATA,
    ST_END,
    ST_RECOV,
    ST_PD_SETUP,
    ST_PD_LOW,
    ST_PD_EXIT
  } psbps_state_e;

endpackage : psbps_pkg

// ===== hw/psbps_ctrl.sv
// Host-side controller driving a pSRAM burst interface and its power sequencing
//
// Overview of operation
// - Read bursts end within 8000 ns
// - Write bursts end within 8000 ns
// - Byte enables steady through a read burst
// - Byte enables steady through a write burst
// - Terminate recovery 26 ns or 70 ns
// - 26 ns after last write datum latched
// - Power enable low 20 ns setup, 70 ns
// - Select high 300 us or 1 us
// - Power-up: 50 us high, select 300 us
// - Write strobe quiet 10 ns after select
// - Power enable and strobe high reading
// - Power-down entry and exit resets memory
`timescale 1ns/1ps
module psbps_ctrl #(
  parameter int T_CHH_US = 300  // Select high hold after power enable rises
) (
  // System
  input wire logic CLOCK,
  input wire logic RST_N,
  // Command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [psbps_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [psbps_pkg::LEN_W-1:0] CMD_LEN,
  input wire logic CMD_LOWER_N,
  input wire logic CMD_UPPER_N,
  output logic CMD_READY,
  // Write data
  input wire logic [psbps_pkg::DATA_W-1:0] WR_DATA,
  output logic WR_ACK,
  // Read data
  output logic [psbps_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  // Completion
  output logic DONE,
  output logic TRUNCATED,
  // Configuration and power control
  input wire logic CFG_BURST_CONT,
  input wire logic PD_REQ,
  input wire logic PD_SLEEP,
  output logic PWR_READY,
  // Memory pins
  output logic MEM_CLK,
  output logic MEM_CE_N,
  output logic MEM_POWER_ENABLE,
  output logic MEM_ADDR_LATCH_N,
  output logic MEM_OE_N,
  output logic MEM_WE_N,
  output logic MEM_LOWER_BYTE_N,
  output logic MEM_UPPER_BYTE_N,
  output logic [psbps_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [psbps_pkg::DATA_W-1:0] MEM_DQ_O,
  output logic MEM_DQ_OE,
  input wire logic [psbps_pkg::DATA_W-1:0] MEM_DQ_I,
  input wire logic MEM_WAIT_N
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam int PWRUP_CYC_I = psbps_pkg::min_cyc(T_CHH_US * psbps_pkg::NS_PER_US);
  localparam int PWRUP_MAX_I = (PWRUP_CYC_I > psbps_pkg::PWRUP_HIGH_CYC) ?
                               PWRUP_CYC_I : psbps_pkg::PWRUP_HIGH_CYC;
  // Counter loads, sized to the counter
  localparam logic [psbps_pkg::CNT_W-1:0] PWRUP_LOAD = PWRUP_MAX_I[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] SLEEP_LOAD = PWRUP_CYC_I[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] PART_LOAD =
    psbps_pkg::EXIT_PART_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] PD_SETUP_LOAD =
    psbps_pkg::PD_SETUP_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] PD_HOLD_LOAD =
    psbps_pkg::PD_HOLD_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] TRB_BL_LOAD =
    psbps_pkg::TRB_BL_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] TRB_CONT_LOAD =
    psbps_pkg::TRB_CONT_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] WR_REC_LOAD =
    psbps_pkg::WR_REC_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] WE_STBY_LOAD =
    psbps_pkg::WE_STBY_CYC[psbps_pkg::CNT_W-1:0];
  localparam logic [psbps_pkg::CNT_W-1:0] WR_LAT_LOAD =
    psbps_pkg::WR_LATENCY[psbps_pkg::CNT_W-1:0];
  // Guard band: a write may wait one cycle for the clock fall, so stop early
  localparam logic [psbps_pkg::CNT_W-1:0] BURST_STOP =
    psbps_pkg::CNT_W'(psbps_pkg::BURST_MAX_CYC - 3);
  localparam logic [psbps_pkg::CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [psbps_pkg::CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [psbps_pkg::LEN_W-1:0] LEN_ONE = 8'h01;
  localparam logic [1:0] PIPE_RISE = 2'h2;

  // Larger of two counter loads
  function automatic logic [psbps_pkg::CNT_W-1:0] cnt_max(
    input logic [psbps_pkg::CNT_W-1:0] a,
    input logic [psbps_pkg::CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction : cnt_max

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  psbps_pkg::psbps_state_e state_r;  // Sequencer state
  logic [psbps_pkg::CNT_W-1:0] wait_cnt_r;  // Timing counter for recoveries
  logic [psbps_pkg::CNT_W-1:0] burst_tmr_r;  // Cycles since select fell
  logic [psbps_pkg::LEN_W-1:0] words_r;  // Words still to move
  logic is_write_r;  // Current burst direction
  logic clk_run;  // Burst clock is toggling
  logic fall_now;  // Burst clock falls at this edge
  logic wait_m_r;  // Wait sync, first stage
  logic wait_s_r;  // Wait sync, second stage
  logic [psbps_pkg::DATA_W-1:0] dq_m_r;  // Read data sync, first stage
  logic [psbps_pkg::DATA_W-1:0] dq_s_r;  // Read data sync, second stage
  logic [1:0] rise_pipe_r;  // Rising edges delayed to line up with sync
  logic rd_take;  // A read word is valid this cycle
  logic over_time;  // Burst is about to run past its limit

  assign clk_run = (state_r == psbps_pkg::ST_LATCH) || (state_r == psbps_pkg::ST_RDATA) ||
                   (state_r == psbps_pkg::ST_WLAT) || (state_r == psbps_pkg::ST_WDATA);
  assign fall_now = clk_run && MEM_CLK;
  // Wait high (ready) on a delayed rising edge marks a valid read word
  assign rd_take = (state_r == psbps_pkg::ST_RDATA) && rise_pipe_r[1] && wait_s_r;
  assign over_time = (burst_tmr_r >= BURST_STOP);

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Wait and read data pass two flops; a released wait reads high
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wait_m_r <= 1'b0;
      wait_s_r <= 1'b0;
      dq_m_r <= 16'h0000;
      dq_s_r <= 16'h0000;
    end else begin
      wait_m_r <= MEM_WAIT_N;
      wait_s_r <= wait_m_r;
      dq_m_r <= MEM_DQ_I;
      dq_s_r <= dq_m_r;
    end
  end

  // Rising edge marker delayed two cycles to match the synchroniser
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rise_pipe_r <= 2'h0;
    end else begin
      rise_pipe_r <= {rise_pipe_r[0], clk_run && !MEM_CLK};
    end
  end

  // ----------------------------------------------------------------
  // Burst clock, divided from the system clock
  // ----------------------------------------------------------------
  // Toggles only while a burst is open; parked low otherwise
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_CLK <= 1'b0;
    end else if (clk_run && (state_r != psbps_pkg::ST_END)) begin
      MEM_CLK <= !MEM_CLK;
    end else begin
      MEM_CLK <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Burst duration timer
  // ----------------------------------------------------------------
  // Counts from select falling so the burst is cut before its limit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      burst_tmr_r <= CNT_ZERO;
    end else if (clk_run) begin
      burst_tmr_r <= burst_tmr_r + CNT_ONE;
    end else begin
      burst_tmr_r <= CNT_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= psbps_pkg::ST_PWRUP;
      wait_cnt_r <= PWRUP_LOAD;
      words_r <= 8'h00;
      is_write_r <= 1'b0;
      CMD_READY <= 1'b0;
      WR_ACK <= 1'b0;
      RD_DATA <= 16'h0000;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      TRUNCATED <= 1'b0;
      PWR_READY <= 1'b0;
      MEM_CE_N <= 1'b1;
      MEM_POWER_ENABLE <= 1'b1;
      MEM_ADDR_LATCH_N <= 1'b1;
      MEM_OE_N <= 1'b1;
      MEM_WE_N <= 1'b1;
      MEM_LOWER_BYTE_N <= 1'b1;
      MEM_UPPER_BYTE_N <= 1'b1;
      MEM_ADDR <= 23'h000000;
      MEM_DQ_O <= 16'h0000;
      MEM_DQ_OE <= 1'b0;
    end else begin
      // One-cycle pulses default low
      WR_ACK <= 1'b0;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      CMD_READY <= 1'b0;
      unique case (state_r)
        // Power-up: enable high and select high for the longer hold
        psbps_pkg::ST_PWRUP: begin
          MEM_POWER_ENABLE <= 1'b1;
          MEM_CE_N <= 1'b1;
          if (wait_cnt_r <= CNT_ONE) begin
            state_r <= psbps_pkg::ST_IDLE;
            PWR_READY <= 1'b1;
            CMD_READY <= 1'b1;
          end else begin
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
          end
        end
        // Idle: power-down takes priority over a new burst
        psbps_pkg::ST_IDLE: begin
          if (PD_REQ) begin
            state_r <= psbps_pkg::ST_PD_SETUP;
            wait_cnt_r <= PD_SETUP_LOAD;
            PWR_READY <= 1'b0;
          end else if (CMD_VALID && CMD_READY) begin
            state_r <= psbps_pkg::ST_LATCH;
            is_write_r <= CMD_WRITE;
            words_r <= (CMD_LEN == 8'h00) ? LEN_ONE : CMD_LEN;
            TRUNCATED <= 1'b0;
            MEM_ADDR <= CMD_ADDR;
            MEM_CE_N <= 1'b0;
            MEM_ADDR_LATCH_N <= 1'b0;
            MEM_POWER_ENABLE <= 1'b1;
            MEM_OE_N <= CMD_WRITE;
            MEM_WE_N <= !CMD_WRITE;
            // Byte enables set once here and held to the end
            MEM_LOWER_BYTE_N <= CMD_LOWER_N;
            MEM_UPPER_BYTE_N <= CMD_UPPER_N;
          end else begin
            CMD_READY <= 1'b1;
          end
        end
        // Address latch across the first rising edge
        psbps_pkg::ST_LATCH: begin
          if (fall_now) begin
            MEM_ADDR_LATCH_N <= 1'b1;
            wait_cnt_r <= WR_LAT_LOAD;
            state_r <= is_write_r ? psbps_pkg::ST_WLAT : psbps_pkg::ST_RDATA;
          end
        end
        // Read: take words while wait says ready
        psbps_pkg::ST_RDATA: begin
          if (rd_take) begin
            RD_DATA <= dq_s_r;
            RD_VALID <= 1'b1;
            words_r <= words_r - LEN_ONE;
          end
          if ((rd_take && (words_r == LEN_ONE)) || over_time) begin
            TRUNCATED <= over_time && !(rd_take && (words_r == LEN_ONE));
            state_r <= psbps_pkg::ST_END;
          end
        end
        // Write latency: rising edges before the first datum
        psbps_pkg::ST_WLAT: begin
          if (over_time) begin
            TRUNCATED <= 1'b1;
            state_r <= psbps_pkg::ST_END;
          end else if (fall_now) begin
            if (wait_cnt_r <= CNT_ONE) begin
              MEM_DQ_O <= WR_DATA;
              MEM_DQ_OE <= 1'b1;
              WR_ACK <= 1'b1;
              state_r <= psbps_pkg::ST_WDATA;
            end else begin
              wait_cnt_r <= wait_cnt_r - CNT_ONE;
            end
          end
        end
        // Write: one datum per burst clock, next one put out on the fall
        psbps_pkg::ST_WDATA: begin
          if (fall_now) begin
            words_r <= words_r - LEN_ONE;
            if ((words_r == LEN_ONE) || over_time) begin
              TRUNCATED <= (words_r != LEN_ONE);
              state_r <= psbps_pkg::ST_END;
            end else begin
              MEM_DQ_O <= WR_DATA;
              WR_ACK <= 1'b1;
            end
          end
        end
        // Close the burst: select, strobes high together, bus released
        psbps_pkg::ST_END: begin
          MEM_CE_N <= 1'b1;
          MEM_OE_N <= 1'b1;
          MEM_WE_N <= 1'b1;
          MEM_ADDR_LATCH_N <= 1'b1;
          MEM_DQ_OE <= 1'b0;
          MEM_LOWER_BYTE_N <= 1'b1;
          MEM_UPPER_BYTE_N <= 1'b1;
          DONE <= 1'b1;
          state_r <= psbps_pkg::ST_RECOV;
          // Longest of terminate, write and standby recoveries
          wait_cnt_r <= cnt_max(cnt_max(CFG_BURST_CONT ? TRB_CONT_LOAD : TRB_BL_LOAD,
                                        is_write_r ? WR_REC_LOAD : CNT_ONE),
                                WE_STBY_LOAD);
        end
        // Recovery before the next access may start
        psbps_pkg::ST_RECOV: begin
          if (wait_cnt_r <= CNT_ONE) begin
            state_r <= psbps_pkg::ST_IDLE;
            CMD_READY <= !PD_REQ;
          end else begin
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
          end
        end
        // Setup before power enable falls
        psbps_pkg::ST_PD_SETUP: begin
          if (wait_cnt_r <= CNT_ONE) begin
            MEM_POWER_ENABLE <= 1'b0;
            wait_cnt_r <= PD_HOLD_LOAD;
            state_r <= psbps_pkg::ST_PD_LOW;
          end else begin
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
          end
        end
        // Power enable low: least hold, then until the request drops
        psbps_pkg::ST_PD_LOW: begin
          if (wait_cnt_r > CNT_ONE) begin
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
          end else if (!PD_REQ) begin
            // Exit doubles as a reset of the memory
            MEM_POWER_ENABLE <= 1'b1;
            wait_cnt_r <= PD_SLEEP ? SLEEP_LOAD : PART_LOAD;
            state_r <= psbps_pkg::ST_PD_EXIT;
          end
        end
        // Select stays high after power enable rises
        psbps_pkg::ST_PD_EXIT: begin
          MEM_CE_N <= 1'b1;
          if (wait_cnt_r <= CNT_ONE) begin
            state_r <= psbps_pkg::ST_IDLE;
            PWR_READY <= 1'b1;
            CMD_READY <= 1'b1;
          end else begin
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
          end
        end
      endcase
    end
  end

endmodule : psbps_ctrl

// ===== test/psbps_ctrl_monitor.sv
// Checker of the controller's memory pin timing
`timescale 1ns/1ps
module psbps_ctrl_monitor #(
  parameter int T_CHH_US = 300  // Select hold after power-up
) (
  // System
  input wire logic CLOCK,
  input wire logic RST_N,
  // Status
  input wire logic CFG_BURST_CONT,
  input wire logic DONE,
  // Memory pins
  input wire logic MEM_CE_N,
  input wire logic MEM_POWER_ENABLE,
  input wire logic MEM_ADDR_LATCH_N,
  input wire logic MEM_OE_N,
  input wire logic MEM_WE_N,
  input wire logic MEM_LOWER_BYTE_N,
  input wire logic MEM_UPPER_BYTE_N
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [15:0] ce_cnt_r;  // Cycles with select low
  logic [15:0] hi_cnt_r;  // Cycles since power enable rose
  logic [15:0] up_cnt_r;  // Cycles since reset release
  // Select-low time
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) ce_cnt_r <= 16'h0000;
    else ce_cnt_r <= MEM_CE_N ? 16'h0000 : ce_cnt_r + 16'h0001;
  end
  // Power enable high time, saturating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) hi_cnt_r <= 16'h0000;
    else if (!MEM_POWER_ENABLE) hi_cnt_r <= 16'h0000;
    else if (hi_cnt_r != 16'hFFFF) hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  // Time since reset, saturating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) up_cnt_r <= 16'h0000;
    else if (up_cnt_r != 16'hFFFF) up_cnt_r <= up_cnt_r + 16'h0001;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence ce_rise_s;  // Burst closes
    $rose(MEM_CE_N);
  endsequence
  sequence pe_fall_s;  // Power-down entry
    $fell(MEM_POWER_ENABLE);
  endsequence
  burst_time_a: assert property (ce_cnt_r < psbps_pkg::BURST_MAX_CYC)
    else $error("burst held too long");
  bytes_steady_a: assert property (!MEM_CE_N && !$past(MEM_CE_N) |->
    $stable(MEM_LOWER_BYTE_N) && $stable(MEM_UPPER_BYTE_N)) else $error("byte pins moved");
  term_recov_a: assert property (CFG_BURST_CONT && $rose(MEM_CE_N) |=>
    MEM_CE_N && MEM_ADDR_LATCH_N) else $error("recovery too short");
  done_edge_a: assert property (DONE |-> ce_rise_s) else $error("done without select rise");
  we_quiet_a: assert property (ce_rise_s |-> MEM_WE_N ##1 MEM_WE_N)
    else $error("write strobe active at standby");
  pd_hold_a: assert property (pe_fall_s |-> !MEM_POWER_ENABLE [*2])
    else $error("power-down too short");
  pd_setup_a: assert property (pe_fall_s |-> MEM_CE_N && $past(MEM_CE_N))
    else $error("power-down while selected");
  exit_hold_a: assert property (!MEM_CE_N |-> hi_cnt_r >= psbps_pkg::EXIT_PART_CYC)
    else $error("select too early after exit");
  power_up_a: assert property (!MEM_CE_N |-> up_cnt_r >= T_CHH_US * 20)
    else $error("select too early after power-up");
  read_we_a: assert property (!MEM_OE_N |-> MEM_WE_N && MEM_POWER_ENABLE)
    else $error("strobe or power wrong in read");
endmodule : psbps_ctrl_monitor

bind psbps_ctrl psbps_ctrl_monitor #(.T_CHH_US(T_CHH_US)) psbps_ctrl_monitor_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .CFG_BURST_CONT(CFG_BURST_CONT), .DONE(DONE),
  .MEM_CE_N(MEM_CE_N), .MEM_POWER_ENABLE(MEM_POWER_ENABLE),
  .MEM_ADDR_LATCH_N(MEM_ADDR_LATCH_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
  .MEM_LOWER_BYTE_N(MEM_LOWER_BYTE_N), .MEM_UPPER_BYTE_N(MEM_UPPER_BYTE_N)
);

// ===== test/psbps_mem_model.sv
// Behavioural pSRAM die answering burst reads and writes
`timescale 1ns/1ps
module psbps_mem_model (
  // Memory pins
  input wire logic mclk,
  input wire logic ce_n,
  input wire logic pe,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic lb_n,
  input wire logic ub_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  // Answer
  output logic [15:0] dq_i,
  output logic wait_n,
  // Read latency in burst clocks
  input wire logic [31:0] lat
);
  logic [15:0] mem [logic [22:0]];  // Stored words
  logic [22:0] a;  // Word pointer
  int n;  // Burst clock rises seen
  // Word of an address never written
  function automatic logic [15:0] blank(input logic [22:0] x);
    return x[15:0] ^ 16'hA5C3;
  endfunction : blank
  // Idle levels, wait pulled up
  initial begin
    wait_n = 1'b1;
    dq_i = 16'h0000;
  end
  // Contents lost in power-down
  always @(negedge pe) mem.delete();
  // One burst per select low
  always @(negedge ce_n) begin
    #1 a = addr;
    n = 0;
    #4 wait_n = !we_n;
    while (!ce_n) begin
      @(posedge mclk or posedge ce_n);
      #1;
      if (!ce_n) begin
        n++;
        if (!we_n && dq_oe) begin  // Latch a write word
          if (!mem.exists(a)) mem[a] = blank(a);
          if (!lb_n) mem[a][7:0] = dq_o[7:0];
          if (!ub_n) mem[a][15:8] = dq_o[15:8];
          a++;
        end else if (!oe_n && n > lat) begin  // Read word after latency
          dq_i = mem.exists(a) ? mem[a] : blank(a);
          wait_n = 1'b1;
          a++;
        end
      end
    end
    #5 wait_n = 1'b1;
    dq_i = ~dq_i;  // Bus released, no pull
  end
endmodule : psbps_mem_model

// ===== test/tb_psbps_ctrl.sv
// Self-checking bench of the pSRAM burst and power controller
`timescale 1ns/1ps
module tb_psbps_ctrl;
  // Design signals
  logic CLOCK, RST_N, CMD_VALID, CMD_WRITE, CMD_LOWER_N, CMD_UPPER_N, CFG_BURST_CONT;
  logic PD_REQ, PD_SLEEP, CMD_READY, WR_ACK, RD_VALID, DONE, TRUNCATED, PWR_READY;
  logic MEM_CLK, MEM_CE_N, MEM_POWER_ENABLE, MEM_ADDR_LATCH_N, MEM_OE_N, MEM_WE_N;
  logic MEM_LOWER_BYTE_N, MEM_UPPER_BYTE_N, MEM_DQ_OE, MEM_WAIT_N;
  logic [22:0] CMD_ADDR, MEM_ADDR;
  logic [15:0] WR_DATA, RD_DATA, MEM_DQ_O, MEM_DQ_I;
  logic [7:0] CMD_LEN;
  int num_errors = 0;  // Mismatches
  int checked = 0;  // Comparisons
  int lat = 1;  // Model read latency
  logic [31:0] rnd = 32'h7F075674;  // Random state
  logic [15:0] shadow [logic [22:0]];  // Expected contents
  // Controller under test, short power-up hold
  psbps_ctrl #(.T_CHH_US(2)) psbps_ctrl_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
    .CMD_LOWER_N(CMD_LOWER_N), .CMD_UPPER_N(CMD_UPPER_N), .CMD_READY(CMD_READY),
    .WR_DATA(WR_DATA), .WR_ACK(WR_ACK), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .DONE(DONE), .TRUNCATED(TRUNCATED), .CFG_BURST_CONT(CFG_BURST_CONT), .PD_REQ(PD_REQ),
    .PD_SLEEP(PD_SLEEP), .PWR_READY(PWR_READY), .MEM_CLK(MEM_CLK), .MEM_CE_N(MEM_CE_N),
    .MEM_POWER_ENABLE(MEM_POWER_ENABLE), .MEM_ADDR_LATCH_N(MEM_ADDR_LATCH_N),
    .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_LOWER_BYTE_N(MEM_LOWER_BYTE_N),
    .MEM_UPPER_BYTE_N(MEM_UPPER_BYTE_N), .MEM_ADDR(MEM_ADDR), .MEM_DQ_O(MEM_DQ_O),
    .MEM_DQ_OE(MEM_DQ_OE), .MEM_DQ_I(MEM_DQ_I), .MEM_WAIT_N(MEM_WAIT_N));
  // Memory die on the far side
  psbps_mem_model psbps_mem_model_i (.mclk(MEM_CLK), .ce_n(MEM_CE_N),
    .pe(MEM_POWER_ENABLE), .oe_n(MEM_OE_N), .we_n(MEM_WE_N), .lb_n(MEM_LOWER_BYTE_N),
    .ub_n(MEM_UPPER_BYTE_N), .addr(MEM_ADDR), .dq_o(MEM_DQ_O), .dq_oe(MEM_DQ_OE),
    .dq_i(MEM_DQ_I), .wait_n(MEM_WAIT_N), .lat(lat));
  // Next random state
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected word at an address
  function automatic logic [15:0] exp_word(input logic [22:0] x);
    return shadow.exists(x) ? shadow[x] : (x[15:0] ^ 16'hA5C3);
  endfunction : exp_word
  // Verdict and end of run
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // One comparison
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  // Bounded wait for a level, edges counted
  task automatic wait_for(ref logic s, input logic v, input int lim, output int t);
    t = 0;
    do begin
      @(posedge CLOCK);
      t++;
    end while (s !== v && t < lim);
    if (s !== v) begin
      num_errors++;
      $display("ERROR %0t wait ran out", $time);
      stop_test();
    end
  endtask : wait_for
  // One burst, write words or check read words
  task automatic burst(input logic wr, input logic [22:0] a, input logic [7:0] n,
      input logic lo, input logic up, input bit cut);
    int t, k, w;
    logic [15:0] d, e;
    logic [22:0] x;
    k = 0;
    x = a;
    w = (n == 8'h00) ? 1 : n;
    d = rnd[15:0];
    @(posedge CLOCK);
    CMD_VALID <= 1'b1;
    CMD_WRITE <= wr;
    CMD_ADDR <= a;
    CMD_LEN <= n;
    CMD_LOWER_N <= lo;
    CMD_UPPER_N <= up;
    WR_DATA <= d;
    wait_for(CMD_READY, 1'b1, 9000, t);
    CMD_VALID <= 1'b0;
    t = 0;
    while (DONE !== 1'b1 && t < 600) begin
      @(posedge CLOCK);
      t++;
      if (WR_ACK === 1'b1) begin  // Word taken, next one presented
        e = exp_word(x);
        shadow[x] = {up ? e[15:8] : d[15:8], lo ? e[7:0] : d[7:0]};
        x++;
        k++;
        d = d + 16'h1357;
        WR_DATA <= d;
      end
      if (RD_VALID === 1'b1) begin
        chk(RD_DATA === exp_word(x), "read word");
        x++;
        k++;
      end
    end
    if (t >= 600) wait_for(DONE, 1'b1, 1, t);
    chk(cut ? k < w : k == w, "word count");
    chk(TRUNCATED === cut, "truncation flag");
  endtask : burst
  // Power-down with a refused command, then exit
  task automatic pd(input logic sl, input int hold);
    int t;
    @(posedge CLOCK);
    PD_SLEEP <= sl;
    PD_REQ <= 1'b1;
    CMD_VALID <= 1'b1;
    wait_for(PWR_READY, 1'b0, 100, t);
    repeat (6) begin
      @(posedge CLOCK);
      chk(MEM_POWER_ENABLE === 1'b0 && MEM_CE_N === 1'b1, "power-down pins");
    end
    PD_REQ <= 1'b0;
    CMD_VALID <= 1'b0;
    shadow.delete();
    wait_for(PWR_READY, 1'b1, 9000, t);
    chk(t >= hold, "exit hold");
  endtask : pd
  // Clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  // Main sequence
  initial begin
    int t;
    {CMD_VALID, CMD_WRITE, CMD_LOWER_N, CMD_UPPER_N, CFG_BURST_CONT, PD_REQ, PD_SLEEP} = '0;
    CMD_ADDR = '0;
    CMD_LEN = '0;
    WR_DATA = '0;
    RST_N = 1'b0;
    repeat (8) @(posedge CLOCK);
    chk(MEM_POWER_ENABLE === 1'b1 && MEM_CE_N === 1'b1, "reset pins");
    RST_N <= 1'b1;
    wait_for(PWR_READY, 1'b1, 9000, t);
    chk(t >= psbps_pkg::PWRUP_HIGH_CYC, "power-up wait");
    $display("test power-up done");
    // Single word, zero length, byte masks
    burst(1'b1, 23'h000010, 8'h00, 1'b0, 1'b0, 1'b0);
    burst(1'b0, 23'h000010, 8'h02, 1'b0, 1'b0, 1'b0);
    burst(1'b1, 23'h000020, 8'h10, 1'b1, 1'b0, 1'b0);
    burst(1'b0, 23'h000020, 8'h10, 1'b0, 1'b0, 1'b0);
    $display("test corners done");
    // Random back-to-back bursts, latency and length mode
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      lat = 1 + 2 * rnd[17:16];
      CFG_BURST_CONT <= rnd[20];
      burst(rnd[19], {15'h0000, rnd[7:0]}, {4'h0, rnd[11:8]}, rnd[21],
        rnd[22] & ~rnd[21], 1'b0);
    end
    $display("test random done");
    // Bursts cut by the time limit
    lat = 1;
    burst(1'b0, 23'h000100, 8'hFF, 1'b0, 1'b0, 1'b1);
    burst(1'b1, 23'h000200, 8'hFF, 1'b0, 1'b0, 1'b1);
    $display("test limit done");
    // Partial and sleep power-down, contents lost
    pd(1'b0, 20);
    pd(1'b1, 40);
    burst(1'b0, 23'h000010, 8'h01, 1'b0, 1'b0, 1'b0);
    $display("test power-down done");
    stop_test();
  end
endmodule : tb_psbps_ctrl
